/* rtl/lcd_timing_pkg.sv */
/*
  Constants, register map and types for the LCD frame timing and
  alternating-drive generator.
  Assumes one clock, each cycle counted as one oscillator clock.
*/
// Summary of operation
// - duty code selects 8..64 lines, or 68
// - fixed oscillator clocks per frame per duty
// - frame mode flips polarity each frame
// - row mode flips polarity every n rows
// - n equals row-count field plus one
// - boost field picks x3, x4, x5, x2
// - waveform bit picks frame or row alternation
// - xor bit mixes row and frame polarity in row mode
// - boost clock is osc/64 or osc/32
// - reset gives x3, /64, frame mode, 68 lines, zeros
package lcd_timing_pkg;

  // ==========================================================
  // register map (byte addresses, wishbone word aligned)
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS = 4'h4;
  localparam int          CFG_W       = 14;

  // ==========================================================
  // control field positions
  localparam int POS_DUTY  = 0;
  localparam int POS_BOOST = 4;
  localparam int POS_DIV   = 6;
  localparam int POS_WAVE  = 7;
  localparam int POS_XOR   = 8;
  localparam int POS_ROWS  = 9;

  typedef struct packed {
    logic [4:0] alt_row_count;
    logic       xor_alt_enable;
    logic       row_wave_sel;
    logic       boost_clock_div_sel;
    logic [1:0] boost_factor_sel;
    logic [3:0] duty_line_count;
  } cfg_t;

  localparam cfg_t CFG_RST = '{alt_row_count: 5'h00, xor_alt_enable: 1'b0,
                               row_wave_sel: 1'b0, boost_clock_div_sel: 1'b0,
                               boost_factor_sel: 2'h0, duty_line_count: 4'h8};

  // ==========================================================
  // frame timing
  localparam logic [3:0]  DUTY_68    = 4'h8;
  localparam logic [6:0]  LINES_68   = 7'h44;
  localparam logic [6:0]  LINE_STEP  = 7'h08;
  localparam int          FRAME_1024 = 1024;
  localparam int          FRAME_1032 = 1032;
  localparam int          FRAME_1040 = 1040;
  localparam int          FRAME_1008 = 1008;
  localparam int          FRAME_1088 = 1088;

  // ==========================================================
  // booster
  localparam logic [4:0]  HALF_DIV64 = 5'h1F;
  localparam logic [4:0]  HALF_DIV32 = 5'h0F;
  localparam logic [2:0]  MULT_X2    = 3'h2;
  localparam logic [2:0]  MULT_X3    = 3'h3;
  localparam logic [2:0]  MULT_X4    = 3'h4;
  localparam logic [2:0]  MULT_X5    = 3'h5;

endpackage : lcd_timing_pkg

/* rtl/lcd_frame_ac_drive_timing.sv */
/*
  Frame timing, alternating-drive polarity and booster clock generator,
  with a classic wishbone register slave.
  Assumes clk is the oscillator clock and the bus master is on clk.
*/
`timescale 1ns/1ps
module lcd_frame_ac_drive_timing (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [6:0]  com_line,
  output logic             frame_start,
  output logic             line_start,
  output logic             ac_polarity,
  output logic      [2:0]  booster_mult,
  output logic             boost_clk
);

  // ==========================================================
  // decode functions
  function automatic logic [6:0] lines_of(input logic [3:0] d);
    lines_of = (d >= lcd_timing_pkg::DUTY_68) ? lcd_timing_pkg::LINES_68
             : 7'((d[2:0] + 4'h1) * lcd_timing_pkg::LINE_STEP);
  endfunction : lines_of

  function automatic logic [10:0] frame_of(input logic [3:0] d);
    unique case (d)
      4'h2:       frame_of = 11'(lcd_timing_pkg::FRAME_1032);
      4'h4:       frame_of = 11'(lcd_timing_pkg::FRAME_1040);
      4'h5, 4'h6: frame_of = 11'(lcd_timing_pkg::FRAME_1008);
      4'h0, 4'h1, 4'h3, 4'h7: frame_of = 11'(lcd_timing_pkg::FRAME_1024);
      default:    frame_of = 11'(lcd_timing_pkg::FRAME_1088);
    endcase
  endfunction : frame_of

  // 1/8 duty needs 128 clocks per line, one bit more than a line number
  function automatic logic [7:0] cpl_of(input logic [3:0] d);
    cpl_of = 8'(frame_of(d) / 11'(lines_of(d)));
  endfunction : cpl_of

  // ==========================================================
  // register slave
  lcd_timing_pkg::cfg_t cfg_q, cfg_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        req;
  logic [31:0] wmask;

  logic [3:0]  duty_q, duty_d;
  logic [7:0]  clk_cnt_q, clk_cnt_d;
  logic [6:0]  line_q, line_d;
  logic [4:0]  row_cnt_q, row_cnt_d, bdiv_q, bdiv_d;
  logic        frame_pol_q, frame_pol_d, row_pol_q, row_pol_d;
  logic        fstart_q, fstart_d, lstart_q, lstart_d;
  logic        ac_q, ac_d, bclk_q, bclk_d;
  logic [2:0]  mult_q, mult_d;
  logic        line_end, frame_end;

  assign req = wb_cyc_i & wb_stb_i;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end
    cfg_d  = cfg_q;
    ack_d  = req & ~ack_q;
    rdat_d = rdat_q;
    if (req && !ack_q) begin
      unique case (wb_adr_i)
        lcd_timing_pkg::ADDR_CTRL:   rdat_d = {18'h0, cfg_q};
        lcd_timing_pkg::ADDR_STATUS: rdat_d = {18'h0, ac_q, row_pol_q, frame_pol_q,
                                               duty_q, line_q};
        default:                     rdat_d = 32'h0;
      endcase
    end
    if (req && ack_q && wb_we_i && wb_adr_i == lcd_timing_pkg::ADDR_CTRL) begin
      cfg_d = lcd_timing_pkg::cfg_t'(((cfg_q & ~wmask[lcd_timing_pkg::CFG_W-1:0])
            | (wb_dat_i[lcd_timing_pkg::CFG_W-1:0] & wmask[lcd_timing_pkg::CFG_W-1:0])));
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q  <= lcd_timing_pkg::CFG_RST;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      cfg_q  <= cfg_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ==========================================================
  // frame and polarity timing
  always_comb begin
    line_end    = (clk_cnt_q == cpl_of(duty_q) - 8'h1);
    frame_end   = line_end && (line_q == lines_of(duty_q) - 7'h1);
    clk_cnt_d   = line_end ? 8'h0 : 8'(clk_cnt_q + 8'h1);
    line_d      = frame_end ? 7'h0 : (line_end ? 7'(line_q + 7'h1) : line_q);
    duty_d      = frame_end ? cfg_q.duty_line_count : duty_q;
    frame_pol_d = frame_pol_q ^ frame_end;
    row_cnt_d   = row_cnt_q;
    row_pol_d   = row_pol_q;
    if (frame_end) begin
      row_cnt_d = 5'h0;
      row_pol_d = 1'b0;
    end else if (line_end) begin
      if (row_cnt_q == cfg_q.alt_row_count) begin
        row_cnt_d = 5'h0;
        row_pol_d = ~row_pol_q;
      end else begin
        row_cnt_d = 5'(row_cnt_q + 5'h1);
      end
    end
    fstart_d = frame_end;
    lstart_d = line_end;
    if (!cfg_q.row_wave_sel) begin
      ac_d = frame_pol_d;
    end else if (cfg_q.xor_alt_enable) begin
      ac_d = row_pol_d ^ frame_pol_d;
    end else begin
      ac_d = row_pol_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_q      <= lcd_timing_pkg::DUTY_68;
      clk_cnt_q   <= 8'h0;
      line_q      <= 7'h0;
      row_cnt_q   <= 5'h0;
      frame_pol_q <= 1'b0;
      row_pol_q   <= 1'b0;
      fstart_q    <= 1'b0;
      lstart_q    <= 1'b0;
      ac_q        <= 1'b0;
    end else begin
      duty_q      <= duty_d;
      clk_cnt_q   <= clk_cnt_d;
      line_q      <= line_d;
      row_cnt_q   <= row_cnt_d;
      frame_pol_q <= frame_pol_d;
      row_pol_q   <= row_pol_d;
      fstart_q    <= fstart_d;
      lstart_q    <= lstart_d;
      ac_q        <= ac_d;
    end
  end

  // ==========================================================
  // booster factor and clock
  always_comb begin
    unique case (cfg_q.boost_factor_sel)
      2'h0: mult_d = lcd_timing_pkg::MULT_X3;
      2'h1: mult_d = lcd_timing_pkg::MULT_X4;
      2'h2: mult_d = lcd_timing_pkg::MULT_X5;
      2'h3: mult_d = lcd_timing_pkg::MULT_X2;
    endcase
    if (bdiv_q >= (cfg_q.boost_clock_div_sel ? lcd_timing_pkg::HALF_DIV32
                                             : lcd_timing_pkg::HALF_DIV64)) begin
      bdiv_d = 5'h0;
      bclk_d = ~bclk_q;
    end else begin
      bdiv_d = 5'(bdiv_q + 5'h1);
      bclk_d = bclk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mult_q <= lcd_timing_pkg::MULT_X3;
      bdiv_q <= 5'h0;
      bclk_q <= 1'b0;
    end else begin
      mult_q <= mult_d;
      bdiv_q <= bdiv_d;
      bclk_q <= bclk_d;
    end
  end

  assign wb_dat_o     = rdat_q;
  assign wb_ack_o     = ack_q;
  assign com_line     = line_q;
  assign frame_start  = fstart_q;
  assign line_start   = lstart_q;
  assign ac_polarity  = ac_q;
  assign booster_mult = mult_q;
  assign boost_clk    = bclk_q;

  // ==========================================================
  // assertions
  logic [10:0] fcnt_q;
  logic        fseen_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fcnt_q  <= 11'h0;
      fseen_q <= 1'b0;
    end else begin
      fcnt_q  <= fstart_q ? 11'h1 : 11'(fcnt_q + 11'h1);
      fseen_q <= fseen_q | fstart_q;
    end
  end

  sequence s_last_clk;
    frame_end;
  endsequence
  sequence s_frame_edge;
    fstart_q && (frame_pol_q != $past(frame_pol_q));
  endsequence

  a_frame_length: assert property (@(posedge clk) disable iff (!nrst)
    fstart_q && fseen_q |-> fcnt_q == frame_of($past(duty_q)))
    else $error("frame length wrong");
  a_last_line: assert property (@(posedge clk) disable iff (!nrst)
    s_last_clk |-> line_q == lines_of(duty_q) - 7'h1 ##1 fstart_q && line_q == 7'h0)
    else $error("frame did not end on last line");
  a_frame_flip: assert property (@(posedge clk) disable iff (!nrst)
    s_last_clk |=> s_frame_edge)
    else $error("frame polarity did not flip");
  a_frame_mode: assert property (@(posedge clk) disable iff (!nrst)
    !$past(cfg_q.row_wave_sel) |-> ac_q == frame_pol_q)
    else $error("frame mode polarity wrong");
  a_xor_mode: assert property (@(posedge clk) disable iff (!nrst)
    $past(cfg_q.row_wave_sel && cfg_q.xor_alt_enable) |-> ac_q == (row_pol_q ^ frame_pol_q))
    else $error("xor mode polarity wrong");
  a_row_interval: assert property (@(posedge clk) disable iff (!nrst)
    line_end && !frame_end && row_cnt_q == cfg_q.alt_row_count |=> row_pol_q != $past(row_pol_q))
    else $error("row polarity did not flip after n rows");
  a_row_restart: assert property (@(posedge clk) disable iff (!nrst)
    fstart_q |-> row_cnt_q == 5'h0 && !row_pol_q)
    else $error("row counter not restarted at frame");
  a_boost_mult: assert property (@(posedge clk) disable iff (!nrst)
    $past(cfg_q.boost_factor_sel) == 2'h3 |-> booster_mult == lcd_timing_pkg::MULT_X2)
    else $error("double boost not selected");
  a_boost_div: assert property (@(posedge clk) disable iff (!nrst)
    bclk_q != $past(bclk_q) && $past(nrst)
      && $past(cfg_q.boost_clock_div_sel) == $past(cfg_q.boost_clock_div_sel, 2)
      |-> $past(bdiv_q) == ($past(cfg_q.boost_clock_div_sel)
      ? lcd_timing_pkg::HALF_DIV32 : lcd_timing_pkg::HALF_DIV64))
    else $error("boost clock half period wrong");
  a_reset_cfg: assert property (@(posedge clk)
    $past(!nrst) |-> cfg_q == lcd_timing_pkg::CFG_RST)
    else $error("reset configuration wrong");
  a_bus_ack: assert property (@(posedge clk) disable iff (!nrst)
    req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("wishbone ack not one cycle");

endmodule : lcd_frame_ac_drive_timing

/* sim/lcd_panel_model.sv */
/*
  Panel-side model: tallies each frame as the drivers would see it.
  Assumes registered one-cycle frame_start and line_start pulses on clk.
*/
`timescale 1ns/1ps
module lcd_panel_model (
  input  wire logic        clk,
  input  wire logic        frame_start,
  input  wire logic        line_start,
  input  wire logic        ac_polarity,
  output logic      [11:0] frame_len,
  output logic      [6:0]  line_cnt,
  output logic      [6:0]  flips,
  output logic             ac_start
);
  logic [11:0] clk_q;
  logic [6:0]  line_q;
  logic [6:0]  flip_q;
  logic        ac_q;
  logic        fs_q;
  // ==========================================================
  // frame tallies, handed out at each frame start
  always_ff @(posedge clk) begin
    ac_q <= ac_polarity;
    fs_q <= frame_start;
    if (frame_start) begin
      frame_len <= clk_q;
      line_cnt  <= line_q;
      flips     <= flip_q;
      ac_start  <= ac_polarity;
      clk_q     <= 12'h001;
      line_q    <= 7'h01;
      flip_q    <= 7'h00;
    end else begin
      clk_q  <= clk_q + 12'h001;
      line_q <= line_q + {6'h00, line_start};
      // flips at the frame edge itself are not row flips
      flip_q <= flip_q + {6'h00, (ac_polarity != ac_q) && !fs_q};
    end
  end
endmodule : lcd_panel_model

/* sim/lcd_frame_ac_drive_timing_bench.sv */
/*
  Self-checking bench for the frame timing and alternating-drive block.
  Assumes one 200 MHz clock and a classic wishbone master on it.
*/
`timescale 1ns/1ps
module lcd_frame_ac_drive_timing_bench;
  logic        clk, nrst, cyc, stb, we, ack, fs, ls, acp, bclk, acs, x, w, a;
  logic [3:0]  adr, sel, d;
  logic [31:0] wdat, dat_o, rdat;
  logic [6:0]  com, lcnt, flips;
  logic [2:0]  mult;
  logic [11:0] flen;
  logic [4:0]  r;
  logic [1:0]  b;
  int          fails, n_compared, seed, i;

  lcd_frame_ac_drive_timing i_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .com_line(com), .frame_start(fs), .line_start(ls),
    .ac_polarity(acp), .booster_mult(mult), .boost_clk(bclk));
  lcd_panel_model i_panel (.clk(clk), .frame_start(fs), .line_start(ls),
    .ac_polarity(acp), .frame_len(flen), .line_cnt(lcnt), .flips(flips), .ac_start(acs));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic wr, input logic [3:0] ad, input logic [31:0] dt);
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= ad; wdat <= dt; sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk);
      while (fs !== 1'b1) @(posedge clk);
    end
    @(posedge clk);
  endtask : frames

  task automatic half(input int exp);
    logic v;
    int   k;
    v = bclk;
    while (bclk === v) @(posedge clk);
    v = bclk;
    k = 0;
    while (bclk === v && k < 99) begin
      @(posedge clk);
      k++;
    end
    chk(k, exp);
  endtask : half

  function automatic logic [6:0] n_lines(input logic [3:0] c);
    return (c < 4'h8) ? 7'((c + 1) * 8) : 7'h44;
  endfunction : n_lines

  function automatic logic [11:0] f_clks(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h3, 4'h7: return 12'h400;
      4'h2: return 12'h408;
      4'h4: return 12'h410;
      4'h5, 4'h6: return 12'h3F0;
      default: return 12'h440;
    endcase
  endfunction : f_clks

  task automatic test_done;
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (95000) @(posedge clk);
    fails++;
    test_done;
  end

  initial begin
    seed = 32'hD928; fails = 0; n_compared = 0;
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0; wdat = 32'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(mult, 3'h3);
    wb(1'b0, lcd_timing_pkg::ADDR_CTRL, 32'h0);
    chk(rdat, 32'h8);
    half(32);
    wb(1'b1, 4'hC, 32'h3FFF);
    wb(1'b0, 4'hC, 32'h0);
    chk(rdat, 32'h0);
    for (i = 0; i < 10; i++) begin
      d = (i < 9) ? 4'(i) : 4'(9 + ($unsigned($random(seed)) % 7));
      b = 2'(i);
      w = i[0];
      wb(1'b1, lcd_timing_pkg::ADDR_CTRL, {24'h0, 1'b0, w, b, d});
      frames(2);
      chk(com, 7'h00);
      chk(flen, f_clks(d));
      chk(lcnt, n_lines(d));
      chk(flips, 7'h00);
      chk(mult, (b == 2'h3) ? 3'h2 : 3'(b) + 3'h3);
      wb(1'b0, lcd_timing_pkg::ADDR_STATUS, 32'h0);
      chk({rdat[13], rdat[10:0]}, {acs, d, 7'h00});
      half(w ? 16 : 32);
      a = acs;
      frames(1);
      chk(acs, !a);
    end
    for (i = 0; i < 6; i++) begin
      d = 4'($unsigned($random(seed)) % 9);
      r = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($random(seed));
      x = i[0];
      wb(1'b1, lcd_timing_pkg::ADDR_CTRL, {18'h0, r, x, 1'b1, 1'b0, 2'h0, d});
      frames(2);
      chk(flips, 7'((n_lines(d) - 1) / (r + 1)));
      a = acs;
      frames(1);
      chk(acs, x ? !a : 1'b0);
    end
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk({mult, acp, fs, com, bclk}, {3'h3, 1'b0, 1'b0, 7'h00, 1'b0});
    wb(1'b0, lcd_timing_pkg::ADDR_CTRL, 32'h0);
    chk(rdat, 32'h8);
    test_done;
  end
endmodule : lcd_frame_ac_drive_timing_bench
